// ===== hw/bus_ownership_flush_handshake.sv
// bus ownership, dual-purpose request pin, flush handshakes, copy direction
// assumes all pins synchronous to clk_i and the bridge keeps its own rules
`timescale 1ns/1ps
module bus_ownership_flush_handshake
(
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic ce_i,
    input  wire logic need_bus_i,
    input  wire logic bus_hold_ack_i,
    input  wire logic bridge_req_or_int_ack_n_i,
    input  wire logic new_master_win_i,
    input  wire logic new_master_flush_n_i,
    output logic      new_master_flush_n_o,
    output logic      new_master_flush_oe_o,
    output logic      master_grant_o,
    input  wire logic intc_unit_ready_i,
    input  wire logic intc_first_irq_i,
    input  wire logic intc_flush_req_i,
    input  wire logic intc_flush_n_i,
    output logic      intc_flush_n_o,
    output logic      intc_flush_oe_o,
    output logic      intc_flush_done_o,
    input  wire logic copy_up_i,
    output logic      byte_copy_direction_o,
    output logic      bus_hold_request_o,
    output logic      int_ack_cycle_o,
    output logic      bridge_bus_request_o
);

    // ---------------------------------------------------------------
    // ownership and pin decode
    // ---------------------------------------------------------------
    logic hold_r;
    logic hold_nxt;
    logic inta_r;
    logic inta_nxt;
    logic breq_r;
    logic breq_nxt;
    logic copy_r;
    logic copy_nxt;
    logic grant_r;
    logic grant_nxt;
    logic armed_r;
    logic armed_nxt;
    logic nm_done;
    logic nm_busy;
    logic nm_start;
    logic ai_start;
    logic ai_done;

    // no restart in the done cycle, before the grant has registered
    assign nm_start = new_master_win_i & ~nm_busy & ~grant_r & ~nm_done;

    always_comb
    begin
        hold_nxt  = need_bus_i;
        inta_nxt  = ~bus_hold_ack_i & (bridge_req_or_int_ack_n_i == sideband_pkg::ACT_N);
        breq_nxt  = bus_hold_ack_i & (bridge_req_or_int_ack_n_i == sideband_pkg::ACT_N);
        copy_nxt  = copy_up_i ? sideband_pkg::COPY_UP : sideband_pkg::COPY_DOWN;
        grant_nxt = grant_r;
        if (nm_done)
        begin
            grant_nxt = 1'b1;
        end
        else if (!new_master_win_i)
        begin
            grant_nxt = 1'b0;
        end
        armed_nxt = armed_r | (intc_unit_ready_i & intc_first_irq_i);
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            hold_r  <= 1'b1;
            inta_r  <= 1'b0;
            breq_r  <= 1'b0;
            copy_r  <= sideband_pkg::COPY_DOWN;
            grant_r <= 1'b0;
            armed_r <= 1'b0;
        end
        else if (ce_i)
        begin
            hold_r  <= hold_nxt;
            inta_r  <= inta_nxt;
            breq_r  <= breq_nxt;
            copy_r  <= copy_nxt;
            grant_r <= grant_nxt;
            armed_r <= armed_nxt;
        end
    end

    // ---------------------------------------------------------------
    // flush handshakes
    // ---------------------------------------------------------------
    flush_handshake u_nm_flush
    (
        .clk_i     (clk_i),
        .reset_i   (reset_i),
        .ce_i      (ce_i),
        .start_i   (nm_start),
        .line_n_i  (new_master_flush_n_i),
        .line_n_o  (new_master_flush_n_o),
        .line_oe_o (new_master_flush_oe_o),
        .busy_o    (nm_busy),
        .done_o    (nm_done)
    );

    assign ai_start = armed_r & intc_flush_req_i;

    flush_handshake u_ai_flush
    (
        .clk_i     (clk_i),
        .reset_i   (reset_i),
        .ce_i      (ce_i),
        .start_i   (ai_start),
        .line_n_i  (intc_flush_n_i),
        .line_n_o  (intc_flush_n_o),
        .line_oe_o (intc_flush_oe_o),
        .busy_o    (),
        .done_o    (ai_done)
    );

    assign intc_flush_done_o     = ai_done;
    assign master_grant_o        = grant_r;
    assign byte_copy_direction_o = copy_r;
    assign bus_hold_request_o    = hold_r;
    assign int_ack_cycle_o       = inta_r;
    assign bridge_bus_request_o  = breq_r;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    property p_hold_in_reset;
        @(posedge clk_i) reset_i |=> bus_hold_request_o;
    endproperty
    a_hold_in_reset: assert property (p_hold_in_reset) else $error("hold low in reset");

    property p_hold_follows;
        @(posedge clk_i) disable iff (reset_i)
            (ce_i && !reset_i) |=> bus_hold_request_o == $past(need_bus_i);
    endproperty
    a_hold_follows: assert property (p_hold_follows) else $error("hold not following");

    property p_inta;
        @(posedge clk_i) disable iff (reset_i)
            (ce_i && !bus_hold_ack_i && !bridge_req_or_int_ack_n_i) |=> int_ack_cycle_o;
    endproperty
    a_inta: assert property (p_inta) else $error("int ack missed");

    property p_breq;
        @(posedge clk_i) disable iff (reset_i)
            (ce_i && bus_hold_ack_i && !bridge_req_or_int_ack_n_i)
            |=> bridge_bus_request_o && !int_ack_cycle_o;
    endproperty
    a_breq: assert property (p_breq) else $error("bridge request missed");

    property p_pulse_one;
        @(posedge clk_i) disable iff (reset_i)
            (ce_i && $fell(new_master_flush_n_o)) |=> new_master_flush_n_o && !new_master_flush_oe_o;
    endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("flush pulse not one clock");

    property p_grant_needs_flush;
        @(posedge clk_i) disable iff (reset_i) $rose(master_grant_o) |-> $past(nm_done);
    endproperty
    a_grant_needs_flush: assert property (p_grant_needs_flush) else $error("grant w/o flush");

    property p_nm_reset;
        @(posedge clk_i) reset_i |=> new_master_flush_n_o && new_master_flush_oe_o;
    endproperty
    a_nm_reset: assert property (p_nm_reset) else $error("flush line not high in reset");

    property p_ai_quiet;
        @(posedge clk_i) disable iff (reset_i) !armed_r |-> intc_flush_n_o;
    endproperty
    a_ai_quiet: assert property (p_ai_quiet) else $error("intc flush early");

    property p_copy;
        @(posedge clk_i) disable iff (reset_i)
            (ce_i && !reset_i) |=> byte_copy_direction_o == $past(copy_up_i);
    endproperty
    a_copy: assert property (p_copy) else $error("copy direction wrong");

    c_grant: cover property (@(posedge clk_i) $rose(master_grant_o));
    c_inta: cover property (@(posedge clk_i) int_ack_cycle_o);
    c_breq: cover property (@(posedge clk_i) bridge_bus_request_o);
    c_ai: cover property (@(posedge clk_i) intc_flush_done_o);

endmodule

// ===== pkg/sideband_pkg.sv
// package for the bus ownership and flush sideband block
// assumes a single 10 MHz clock domain and synchronous reset
package sideband_pkg;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int  CLK_PERIOD_NS    = 100;
    localparam int  FLUSH_PULSE_NS   = 100;
    localparam int  FLUSH_PULSE_CYC  = (FLUSH_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ---------------------------------------------------------------
    // pin levels
    // ---------------------------------------------------------------
    localparam logic ACT_N           = 1'h0;
    localparam logic INACT_N         = 1'h1;
    localparam logic COPY_UP         = 1'h1;
    localparam logic COPY_DOWN       = 1'h0;

    // ---------------------------------------------------------------
    // flush handshake states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        FL_IDLE,
        FL_PULSE,
        FL_WAIT
    } flush_state_t;

endpackage

// ===== hw/flush_handshake.sv
// one side of a two-phase flush handshake on a shared active-low line
// assumes the far end drives the line while this end releases it
`timescale 1ns/1ps
module flush_handshake
(
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic ce_i,
    input  wire logic start_i,
    input  wire logic line_n_i,
    output logic      line_n_o,
    output logic      line_oe_o,
    output logic      busy_o,
    output logic      done_o
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    sideband_pkg::flush_state_t state_r;
    sideband_pkg::flush_state_t state_nxt;
    logic                       line_n_r;
    logic                       line_n_nxt;
    logic                       oe_r;
    logic                       oe_nxt;
    logic                       done_r;
    logic                       done_nxt;
    logic                       seen_low_r;
    logic                       seen_low_nxt;

    always_comb
    begin
        state_nxt    = state_r;
        line_n_nxt   = line_n_r;
        oe_nxt       = oe_r;
        done_nxt     = 1'b0;
        seen_low_nxt = seen_low_r;
        case (state_r)
            sideband_pkg::FL_IDLE:
            begin
                line_n_nxt = sideband_pkg::INACT_N;
                oe_nxt     = 1'b1;
                if (start_i)
                begin
                    // request pulse, one clock
                    line_n_nxt = sideband_pkg::ACT_N;
                    state_nxt  = sideband_pkg::FL_PULSE;
                end
            end
            sideband_pkg::FL_PULSE:
            begin
                // release to the far end
                line_n_nxt   = sideband_pkg::INACT_N;
                oe_nxt       = 1'b0;
                seen_low_nxt = 1'b0;
                state_nxt    = sideband_pkg::FL_WAIT;
            end
            default:
            begin
                if (line_n_i == sideband_pkg::ACT_N)
                begin
                    seen_low_nxt = 1'b1;
                end
                else if (seen_low_r)
                begin
                    // flushed: resume default drive
                    oe_nxt    = 1'b1;
                    done_nxt  = 1'b1;
                    state_nxt = sideband_pkg::FL_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            state_r    <= sideband_pkg::FL_IDLE;
            line_n_r   <= sideband_pkg::INACT_N;
            oe_r       <= 1'b1;
            done_r     <= 1'b0;
            seen_low_r <= 1'b0;
        end
        else if (ce_i)
        begin
            state_r    <= state_nxt;
            line_n_r   <= line_n_nxt;
            oe_r       <= oe_nxt;
            done_r     <= done_nxt;
            seen_low_r <= seen_low_nxt;
        end
    end

    assign line_n_o  = line_n_r;
    assign line_oe_o = oe_r;
    assign busy_o    = (state_r != sideband_pkg::FL_IDLE);
    assign done_o    = done_r;

endmodule

// ===== verif/bridge_flush_model.sv
// bridge-side responder for one shared active-low flush line
// assumes the bench resolves the wire level and feeds it back on line_n_i
`timescale 1ns/1ps
module bridge_flush_model
(
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic [3:0] delay_i,
    input  wire logic       line_n_i,
    output logic            drv_n_o,
    output logic            oe_o
);
    logic       low_r;
    logic       high_r;
    logic [3:0] cnt_r;
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            low_r  <= 1'h0;
            high_r <= 1'h0;
            cnt_r  <= 4'h0;
        end
        else
        begin
            high_r <= low_r && cnt_r == 4'h0;
            if (low_r && cnt_r == 4'h0)
                low_r <= 1'h0;
            else if (!low_r && !high_r && !line_n_i)
            begin
                low_r <= 1'h1;
                cnt_r <= delay_i;
            end
            else if (cnt_r != 4'h0)
                cnt_r <= cnt_r - 4'h1;
        end
    end
    assign drv_n_o = high_r;
    assign oe_o    = low_r | high_r;
endmodule

// ===== verif/tb.sv
// self-checking bench for the ownership and flush sideband block
// assumes two bridge flush responders and the bench acting as bridge pins
`timescale 1ns/1ps
module tb;
    logic clk_i = 1'h0, reset_i = 1'h1, ce_i = 1'h1, need_bus_i = 1'h0, ack = 1'h0;
    logic pin_n = 1'h1, win = 1'h0, rdy = 1'h0, irq = 1'h0, ic_req = 1'h0, copy_up = 1'h0;
    logic nm_n, nm_oe, grant, ic_n, ic_oe, ic_done, copy_o, hold_o, inta_o, breq_o;
    logic br_nm_n, br_nm_oe, br_ic_n, br_ic_oe, nm_last = 1'h1, ic_last = 1'h1;
    logic [3:0] nm_dly = 4'h0;
    wire  nm_line = nm_oe ? nm_n : (br_nm_oe ? br_nm_n : ~nm_last);
    wire  ic_line = ic_oe ? ic_n : (br_ic_oe ? br_ic_n : ~ic_last);
    int   bad_count = 0, checked = 0;
    localparam logic [31:0] SD_WORD = 32'h44332211;
    // bridge lane copy in the selected direction
    wire  [31:0] sd_out = copy_o ? {SD_WORD[15:0], SD_WORD[15:0]}
                                 : {SD_WORD[31:16], SD_WORD[31:16]};
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        nm_last <= nm_line;
        ic_last <= ic_line;
    end
    // ---------------------------------------------------------------
    // design and bridge models
    // ---------------------------------------------------------------
    bus_ownership_flush_handshake u_dut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
        .need_bus_i(need_bus_i), .bus_hold_ack_i(ack), .bridge_req_or_int_ack_n_i(pin_n),
        .new_master_win_i(win), .new_master_flush_n_i(nm_line), .new_master_flush_n_o(nm_n),
        .new_master_flush_oe_o(nm_oe), .master_grant_o(grant), .intc_unit_ready_i(rdy),
        .intc_first_irq_i(irq), .intc_flush_req_i(ic_req), .intc_flush_n_i(ic_line),
        .intc_flush_n_o(ic_n), .intc_flush_oe_o(ic_oe), .intc_flush_done_o(ic_done),
        .copy_up_i(copy_up), .byte_copy_direction_o(copy_o), .bus_hold_request_o(hold_o),
        .int_ack_cycle_o(inta_o), .bridge_bus_request_o(breq_o));
    bridge_flush_model u_br_nm (.clk_i(clk_i), .reset_i(reset_i), .delay_i(nm_dly),
        .line_n_i(nm_line), .drv_n_o(br_nm_n), .oe_o(br_nm_oe));
    bridge_flush_model u_br_ic (.clk_i(clk_i), .reset_i(reset_i), .delay_i(4'h2),
        .line_n_i(ic_line), .drv_n_o(br_ic_n), .oe_o(br_ic_oe));
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task chk(input logic v, input logic e);
        checked++;
        if (v !== e)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, v, e);
        end
    endtask
    task settle;
        @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task conclude;
        $display("checks %0d errors %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task t_hold_decode;
        int i;
        @(posedge clk_i) need_bus_i <= 1'h0;
        settle;
        chk(hold_o, 1'h0);
        @(posedge clk_i) need_bus_i <= 1'h1;
        settle;
        chk(hold_o, 1'h1);
        for (i = 0; i < 4; i++)
        begin
            @(posedge clk_i)
            begin
                ack   <= i[1];
                pin_n <= i[0];
            end
            settle;
            chk(inta_o, !i[1] && !i[0]);
            chk(breq_o, i[1] && !i[0]);
        end
    endtask
    task t_copy;
        @(posedge clk_i)
        begin
            ce_i    <= 1'h0;
            copy_up <= 1'h1;
        end
        settle;
        chk(copy_o, 1'h0);
        @(posedge clk_i) ce_i <= 1'h1;
        settle;
        chk(copy_o, 1'h1);
        chk(sd_out == 32'h22112211, 1'h1);
        @(posedge clk_i) copy_up <= 1'h0;
        settle;
        chk(copy_o, 1'h0);
        chk(sd_out == 32'h44334433, 1'h1);
    endtask
    task t_nm(input logic [3:0] d);
        int k;
        @(posedge clk_i)
        begin
            nm_dly <= d;
            win    <= 1'h1;
        end
        settle;
        chk(nm_n, 1'h0);
        @(negedge clk_i);
        chk(nm_oe, 1'h0);
        k = 0;
        while (grant !== 1'h1 && k < 40)
        begin
            chk(grant, 1'h0);
            @(negedge clk_i);
            k++;
        end
        chk(k == int'(d) + 3, 1'h1);
        chk(nm_oe & nm_n, 1'h1);
        repeat (3) @(negedge clk_i);
        chk(nm_oe & nm_n & grant, 1'h1);
        @(posedge clk_i) win <= 1'h0;
        settle;
        chk(grant, 1'h0);
    endtask
    task t_intc;
        int k;
        @(posedge clk_i)
        begin
            ic_req <= 1'h1;
            rdy    <= 1'h1;
        end
        repeat (4) settle;
        chk(ic_oe & ic_n, 1'h1);
        @(posedge clk_i) irq <= 1'h1;
        k = 0;
        while (ic_line !== 1'h0 && k < 40)
        begin
            @(negedge clk_i);
            k++;
        end
        chk(k == 3, 1'h1);
        @(posedge clk_i) ic_req <= 1'h0;
        while (ic_done !== 1'h1 && k < 40)
        begin
            @(negedge clk_i);
            k++;
        end
        chk(k == 8, 1'h1);
        chk(ic_done, 1'h1);
        chk(ic_oe & ic_n, 1'h1);
        @(negedge clk_i);
        chk(ic_done, 1'h0);
    endtask
    // ---------------------------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------------------------
    initial
    begin
        repeat (5) @(negedge clk_i);
        chk(hold_o, 1'h1);
        chk(nm_oe & nm_n & ic_oe & ic_n, 1'h1);
        chk(grant | copy_o, 1'h0);
        @(posedge clk_i) reset_i <= 1'h0;
        t_hold_decode;
        t_copy;
        t_nm(4'h0);
        t_nm(4'h5);
        t_intc;
        conclude;
    end
    initial
    begin
        repeat (2000) @(posedge clk_i);
        bad_count++;
        conclude;
    end
endmodule
